// file: dv/slx_ctrl_partner.sv
// Far-end transmitter model sending a pseudo-random bit stream on every lane
module slx_ctrl_partner
    import slx_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Stream control
    input  wire logic [1:0] pattern_i,
    input  wire logic [7:0] flip_i,
    // Lanes towards the receiver
    output logic      [7:0] lane_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [30:0] hist_r;
    logic        next_bit;
    // Lane k carries the same stream k bits later; flip_i inverts every lane whose bit is set
    assign lane_o   = hist_r[7:0] ^ flip_i;
    assign next_bit = (pattern_i == PAT_PRBS15) ? (hist_r[14] ^ hist_r[13]) :
                      (pattern_i == PAT_PRBS31) ? (hist_r[30] ^ hist_r[27]) :
                                                  (hist_r[6] ^ hist_r[5]);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            hist_r <= 31'h7fff_ffff;
        else
            hist_r <= {hist_r[29:0], next_bit};
    end
endmodule

// file: dv/slx_ctrl_properties.sv
// Port-level assertions for the lane crossbar, sync error and bit-error test controller
module slx_ctrl_properties
    import slx_pkg::*;
(
    // Clock, reset, register port, status and outputs
    input wire logic [0:0]           clk_i,
    input wire logic [0:0]           rst_i,
    input wire logic [ADDR_W-1:0]    reg_addr_i,
    input wire logic [7:0]           reg_wdata_i,
    input wire logic [0:0]           reg_wr_i,
    input wire logic [0:0]           reg_rd_i,
    input wire logic [7:0]           reg_rdata_o,
    input wire logic [0:0]           reg_rvalid_o,
    input wire logic [NUM_LANES-1:0] lane_buf_full_i,
    input wire logic [NUM_LANES-1:0] lane_buf_empty_i,
    input wire logic [NUM_LINKS-1:0] multiframe_end_i,
    input wire logic [NUM_LINKS-1:0] sync_request_output_n_o,
    input wire logic [7:0]           serializer_setup_value_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_rvalid;
        reg_rvalid_o == $past(reg_rd_i); endproperty
    property p_full;
        reg_rd_i && reg_addr_i == OFS_FULL |=> reg_rdata_o == $past(lane_buf_full_i); endproperty
    property p_empty;
        reg_rd_i && reg_addr_i == OFS_EMPTY |=> reg_rdata_o == $past(lane_buf_empty_i); endproperty
    property p_map_rsv;
        reg_rd_i && reg_addr_i inside {[OFS_MAP_0_1:OFS_MAP_6_7]} |=> !reg_rdata_o[7:6]; endproperty
    property p_ctl_rsv;
        reg_rd_i && reg_addr_i == OFS_BERT_CT |=> !reg_rdata_o[7]; endproperty
    property p_hold;
        !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    property p_ser;
        reg_wr_i && reg_addr_i == OFS_SERDES |=> serializer_setup_value_o == $past(reg_wdata_i); endproperty
    property p_sync;
        (~sync_request_output_n_o & ~($past(multiframe_end_i) | $past(multiframe_end_i, 2))) == 2'b00; endproperty
    a_rvalid:  assert property (p_rvalid)  else $error("read valid not one cycle after read");
    a_full:    assert property (p_full)    else $error("full flags read wrong");
    a_empty:   assert property (p_empty)   else $error("empty flags read wrong");
    a_map_rsv: assert property (p_map_rsv) else $error("lane map spare bits not zero");
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("test control spare bit not zero");
    a_hold:    assert property (p_hold)    else $error("read data changed without read");
    a_ser:     assert property (p_ser)     else $error("serializer value not written");
    a_sync:    assert property (p_sync)    else $error("sync low without multiframe end");
    c_sync: cover property (!sync_request_output_n_o[0]);
    c_cnt:  cover property (reg_rd_i && reg_addr_i == OFS_CNT_LO);
    c_ser:  cover property (reg_wr_i && reg_addr_i == OFS_SERDES);
endmodule
bind slx_ctrl slx_ctrl_properties u_props (
    .clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .reg_rvalid_o, .lane_buf_full_i, .lane_buf_empty_i, .multiframe_end_i,
    .sync_request_output_n_o, .serializer_setup_value_o
);

// file: dv/slx_ctrl_tb.sv
// Self-checking bench for the lane crossbar, sync error and bit-error test controller
module slx_ctrl_tb
    import slx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic [ADDR_W-1:0]    reg_addr_i = '0;
    logic [7:0]           reg_wdata_i = '0;
    logic                 reg_wr_i = 1'b0;
    logic                 reg_rd_i = 1'b0;
    logic [7:0]           reg_rdata_o;
    logic                 reg_rvalid_o;
    logic [NUM_LANES-1:0] serial_input_lane_i;
    logic [NUM_LANES-1:0] logical_lane_o;
    logic [NUM_LANES-1:0] lane_buf_full_i = 8'ha5;
    logic [NUM_LANES-1:0] lane_buf_empty_i = 8'h5a;
    logic [NUM_LANES-1:0] flip = '0;
    logic [1:0]           pat = PAT_PRBS7;
    logic [NUM_LINKS-1:0] multiframe_end_i = '0;
    logic [NUM_LINKS-1:0] err_v [3] = '{default: '0};
    logic [NUM_LINKS-1:0] sync_request_output_n_o;
    logic [7:0]           serializer_setup_value_o;
    int                   err_total = 0;
    int                   checks = 0;
    int                   cyc = 0;
    slx_ctrl u_dut (
        .clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .reg_rvalid_o, .serial_input_lane_i, .logical_lane_o, .lane_buf_full_i,
        .lane_buf_empty_i, .multiframe_end_i, .disparity_err_i(err_v[0]),
        .not_in_table_err_i(err_v[1]), .unexp_ctrl_err_i(err_v[2]),
        .sync_request_output_n_o, .serializer_setup_value_o
    );
    slx_ctrl_partner u_far (
        .clk_i, .rst_i, .pattern_i(pat), .flip_i(flip), .lane_o(serial_input_lane_i)
    );
    initial
        forever #12.5 clk_i = ~clk_i;
    task automatic report_and_stop();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_i) reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i) reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk($sformatf("reg %h", a), d, exp);
    endtask
    task automatic sync_run(input int k, input int e, input logic [1:0] t);
        wr(OFS_SYNC, {2'b00, t, 4'h0});
        @(posedge clk_i) multiframe_end_i[k] <= 1'b1;
        if (e < 3)
            err_v[e][k] <= 1'b1;
        @(posedge clk_i) multiframe_end_i <= '0;
        err_v <= '{default: '0};
        #1 chk("sync first", sync_request_output_n_o[k], e == 3);
        @(negedge clk_i) #1 chk("sync half", sync_request_output_n_o[k], e == 3 || t == DUR_HALF);
        @(posedge clk_i) #1 chk("sync second", sync_request_output_n_o[k],
                                 e == 3 || t == DUR_HALF || t == DUR_ONE);
        @(posedge clk_i) #1 chk("sync idle", sync_request_output_n_o[k], 1'b1);
    endtask
    task automatic xbar(input logic [2:0] src [8]);
        logic [3:0][7:0] h;
        h = '0;
        for (int c = 0; c < 16; c++)
        begin
            @(negedge clk_i) h = {h[2:0], serial_input_lane_i};
            for (int n = 0; n < 8; n++)
                if (c > 3)
                    chk("logical lane", logical_lane_o[n], h[3][src[n]]);
        end
    endtask
    initial
    begin
        logic [7:0] d;
        logic [2:0] src [8];
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(OFS_MAP_4_5, RST_MAP_4_5);
        rchk(OFS_PASS, RST_PASS);
        rchk(OFS_BERT_EN, RST_ZERO);
        rchk(OFS_CNT_HI, RST_ZERO);
        rchk(OFS_SERDES, RST_ZERO);
        wr(OFS_FULL, 8'h00);
        rchk(OFS_FULL, 8'ha5);
        @(posedge clk_i) lane_buf_empty_i <= 8'hc3;
        rchk(OFS_EMPTY, 8'hc3);
        wr(OFS_SERDES, 8'h01);
        chk("serializer", serializer_setup_value_o, 8'h01);
        foreach (src[n]) src[n] = n[2:0];
        xbar(src);
        wr(OFS_MAP_0_1, 8'h37);
        wr(OFS_MAP_2_3, 8'h25);
        wr(OFS_MAP_4_5, 8'h13);
        wr(OFS_MAP_6_7, 8'hc1);
        rchk(OFS_MAP_6_7, 8'h01);
        foreach (src[n]) src[n] = 3'd7 - n[2:0];
        xbar(src);
        for (int k = 0; k < 2; k++)
            for (int e = 0; e < 4; e++)
                for (int t = 0; t < 4; t++)
                    sync_run(k, e, t[1:0]);
        @(posedge clk_i) err_v[1] <= 2'b01;
        @(posedge clk_i) err_v[1] <= '0;
        repeat (3) @(posedge clk_i);
        multiframe_end_i <= 2'b11;
        @(posedge clk_i) multiframe_end_i <= '0;
        #1 chk("sync stored", sync_request_output_n_o, 8'h02);
        wr(OFS_BERT_CT, 8'h81);
        rchk(OFS_BERT_CT, 8'h01);
        wr(OFS_LIM_LO, 8'h03);
        wr(OFS_BERT_EN, 8'h09);
        wr(OFS_BERT_CT, 8'h32);
        repeat (60) @(posedge clk_i);
        rchk(OFS_CNT_LO, 8'h00);
        @(posedge clk_i) flip <= 8'h28;
        @(posedge clk_i) flip <= '0;
        repeat (20) @(posedge clk_i);
        rchk(OFS_CNT_LO, 8'h03);
        rchk(OFS_CNT_MI, 8'h00);
        rchk(OFS_PASS, 8'hf7);
        wr(OFS_BERT_CT, 8'h52);
        rchk(OFS_CNT_LO, 8'h00);
        wr(OFS_BERT_CT, 8'h33);
        rchk(OFS_CNT_LO, 8'h00);
        rchk(OFS_PASS, RST_PASS);
        wr(OFS_BERT_CT, 8'h30);
        @(posedge clk_i) flip <= 8'h08;
        @(posedge clk_i) flip <= '0;
        repeat (20) @(posedge clk_i);
        rchk(OFS_CNT_LO, 8'h00);
        for (int p = 1; p < 3; p++)
        begin
            wr(OFS_BERT_CT, 8'h31);
            wr(OFS_BERT_CT, 8'h32 | 8'(p << 2));
            repeat (80) @(posedge clk_i);
            rd(OFS_CNT_LO, d);
            chk("pattern mismatch", d != 8'h00, 1'b1);
            @(posedge clk_i) pat <= p[1:0];
            wr(OFS_BERT_CT, 8'h31);
            wr(OFS_BERT_CT, 8'h32 | 8'(p << 2));
            repeat (80) @(posedge clk_i);
            rchk(OFS_CNT_LO, RST_ZERO);
        end
        report_and_stop();
    end
endmodule

// file: verilog/slx_bert_lane.sv
// One lane of the self-synchronising pseudo-random bit-error checker
module slx_bert_lane
    import slx_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Control
    input  wire logic              run_i,
    input  wire logic              hold_i,
    input  wire logic [1:0]        pattern_i,
    // Received bit
    input  wire logic              rx_bit_i,
    // Result
    output logic      [CNT_W-1:0]  err_count_o
);
    logic [30:0]      hist_r;
    logic [4:0]       fill_r;
    logic [CNT_W-1:0] cnt_r;
    wire              expect_bit;
    wire              mismatch;
    wire              saturated;

    assign expect_bit = (pattern_i == PAT_PRBS7)  ? (hist_r[6]  ^ hist_r[5])  :
                        (pattern_i == PAT_PRBS15) ? (hist_r[14] ^ hist_r[13]) :
                                                    (hist_r[30] ^ hist_r[27]);
    assign mismatch   = run_i && (fill_r == FILL_BITS) && (rx_bit_i != expect_bit);
    assign saturated  = &cnt_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || hold_i)
        begin
            hist_r <= '0;
            fill_r <= '0;
            cnt_r  <= '0;
        end
        else if (run_i)
        begin
            hist_r <= {hist_r[29:0], rx_bit_i};
            fill_r <= (fill_r == FILL_BITS) ? fill_r : fill_r + 5'd1;
            if (mismatch && !saturated)
                cnt_r <= cnt_r + 24'd1;
        end
    end

    assign err_count_o = cnt_r;
endmodule

// file: verilog/slx_ctrl.sv
// Lane crossbar, lane buffer status, sync error generation and lane bit-error test
// Overview of operation
// - Each logical lane has a 3-bit source field choosing physical lane x.
// - After reset logical lane n takes data from physical lane n.
// - Read-only vector shows which logical lane buffers are full.
// - Read-only vector shows which logical lane buffers are empty.
// - At multiframe end, any character error drives the sync output low.
// - Duration field sets sync low time: half, one or two cycles.
// - Test-enable vector bit x enables the bit-error test on lane x.
// - Error-source field chooses which lane count the count bytes show.
// - Pattern field picks PRBS7, PRBS15 or PRBS31.
// - Test-start bit runs the bit-error test while 1.
// - Test-reset bit holds test state and counters in reset while 1.
// - Selected lane's 24-bit error count is read as three bytes.
// - Pass vector resets to all ones; bit clears once count reaches limit.
module slx_ctrl
    import slx_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Register port
    input  wire logic [ADDR_W-1:0]     reg_addr_i,
    input  wire logic [7:0]            reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [7:0]            reg_rdata_o,
    output logic                       reg_rvalid_o,
    // Serial lanes
    input  wire logic [NUM_LANES-1:0]  serial_input_lane_i,
    output logic      [NUM_LANES-1:0]  logical_lane_o,
    // Lane buffer status
    input  wire logic [NUM_LANES-1:0]  lane_buf_full_i,
    input  wire logic [NUM_LANES-1:0]  lane_buf_empty_i,
    // Link character checks
    input  wire logic [NUM_LINKS-1:0]  multiframe_end_i,
    input  wire logic [NUM_LINKS-1:0]  disparity_err_i,
    input  wire logic [NUM_LINKS-1:0]  not_in_table_err_i,
    input  wire logic [NUM_LINKS-1:0]  unexp_ctrl_err_i,
    output logic      [NUM_LINKS-1:0]  sync_request_output_n_o,
    // Serializer setup
    output logic      [7:0]            serializer_setup_value_o
);
    function automatic logic [2:0] lane_src(input logic [7:0] map [4], input int n);
        lane_src = (n % 2 == 0) ? map[n/2][MAP_LO_POS +: 3] : map[n/2][MAP_HI_POS +: 3];
    endfunction

    function automatic logic [7:0] cnt_byte(input logic [CNT_W-1:0] v, input int b);
        cnt_byte = v[b*8 +: 8];
    endfunction

    logic [7:0]           map_r [4];
    logic [7:0]           sync_cfg_r;
    logic [7:0]           serdes_r;
    logic [7:0]           bert_en_r;
    logic [7:0]           bert_ct_r;
    logic [CNT_W-1:0]     limit_r;
    logic [NUM_LANES-1:0] pass_r;
    logic [NUM_LANES-1:0] lane_s1_r;
    logic [NUM_LANES-1:0] lane_s2_r;
    logic [NUM_LANES-1:0] xbar_r;
    logic [7:0]           rdata_r;
    logic                 rvalid_r;
    logic [NUM_LINKS-1:0] err_acc_r;
    logic [NUM_LINKS-1:0] low_r;
    logic [NUM_LINKS-1:0] half_r;
    logic [1:0]           low_cnt_r [NUM_LINKS];
    logic [CNT_W-1:0]     err_cnt [NUM_LANES];
    logic [7:0]           rd_mux;

    wire                  bert_run;
    wire                  bert_hold;
    wire  [1:0]           bert_pat;
    wire  [2:0]           err_sel;
    wire  [1:0]           low_dur;
    wire  [CNT_W-1:0]     sel_cnt;
    wire  [NUM_LINKS-1:0] char_err;
    wire  [NUM_LINKS-1:0] raise_err;

    assign bert_run  = bert_ct_r[RUN_POS];
    assign bert_hold = bert_ct_r[HOLD_POS];
    assign bert_pat  = bert_ct_r[PAT_POS +: 2];
    assign err_sel   = bert_ct_r[SEL_POS +: 3];
    assign low_dur   = sync_cfg_r[DUR_POS +: 2];
    assign sel_cnt   = err_cnt[err_sel];
    assign char_err  = disparity_err_i | not_in_table_err_i | unexp_ctrl_err_i;
    assign raise_err = multiframe_end_i & (err_acc_r | char_err);

    // Register writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            map_r[0]   <= RST_MAP_0_1;
            map_r[1]   <= RST_MAP_2_3;
            map_r[2]   <= RST_MAP_4_5;
            map_r[3]   <= RST_MAP_6_7;
            sync_cfg_r <= RST_ZERO;
            serdes_r   <= RST_ZERO;
            bert_en_r  <= RST_ZERO;
            bert_ct_r  <= RST_ZERO;
            limit_r    <= '0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                OFS_MAP_0_1: map_r[0]   <= {2'b00, reg_wdata_i[5:0]};
                OFS_MAP_2_3: map_r[1]   <= {2'b00, reg_wdata_i[5:0]};
                OFS_MAP_4_5: map_r[2]   <= {2'b00, reg_wdata_i[5:0]};
                OFS_MAP_6_7: map_r[3]   <= {2'b00, reg_wdata_i[5:0]};
                OFS_SYNC:    sync_cfg_r <= reg_wdata_i;
                OFS_SERDES:  serdes_r   <= reg_wdata_i;
                OFS_BERT_EN: bert_en_r  <= reg_wdata_i;
                OFS_BERT_CT: bert_ct_r  <= {1'b0, reg_wdata_i[6:0]};
                OFS_LIM_LO:  limit_r[7:0]   <= reg_wdata_i;
                OFS_LIM_MI:  limit_r[15:8]  <= reg_wdata_i;
                OFS_LIM_HI:  limit_r[23:16] <= reg_wdata_i;
                default:     limit_r    <= limit_r;
            endcase
        end
    end

    // Read selection
    always_comb
    begin
        case (reg_addr_i)
            OFS_MAP_0_1: rd_mux = map_r[0];
            OFS_MAP_2_3: rd_mux = map_r[1];
            OFS_MAP_4_5: rd_mux = map_r[2];
            OFS_MAP_6_7: rd_mux = map_r[3];
            OFS_FULL:    rd_mux = lane_buf_full_i;
            OFS_EMPTY:   rd_mux = lane_buf_empty_i;
            OFS_SYNC:    rd_mux = sync_cfg_r;
            OFS_SERDES:  rd_mux = serdes_r;
            OFS_BERT_EN: rd_mux = bert_en_r;
            OFS_BERT_CT: rd_mux = bert_ct_r;
            OFS_LIM_LO:  rd_mux = limit_r[7:0];
            OFS_LIM_MI:  rd_mux = limit_r[15:8];
            OFS_LIM_HI:  rd_mux = limit_r[23:16];
            OFS_CNT_LO:  rd_mux = cnt_byte(sel_cnt, 0);
            OFS_CNT_MI:  rd_mux = cnt_byte(sel_cnt, 1);
            OFS_CNT_HI:  rd_mux = cnt_byte(sel_cnt, 2);
            OFS_PASS:    rd_mux = pass_r;
            default:     rd_mux = RST_ZERO;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_r  <= RST_ZERO;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r  <= reg_rd_i ? rd_mux : rdata_r;
            rvalid_r <= reg_rd_i;
        end
    end

    // Lane pin synchroniser and crossbar
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lane_s1_r <= '0;
            lane_s2_r <= '0;
            xbar_r    <= '0;
        end
        else
        begin
            lane_s1_r <= serial_input_lane_i;
            lane_s2_r <= lane_s1_r;
            for (int n = 0; n < NUM_LANES; n++)
                xbar_r[n] <= lane_s2_r[lane_src(map_r, n)];
        end
    end

    // Bit-error checkers and pass vector
    for (genvar g = 0; g < NUM_LANES; g++)
    begin : g_bert
        slx_bert_lane u_lane (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .run_i       (bert_run && bert_en_r[g]),
            .hold_i      (bert_hold),
            .pattern_i   (bert_pat),
            .rx_bit_i    (lane_s2_r[g]),
            .err_count_o (err_cnt[g])
        );
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || bert_hold)
            pass_r <= RST_PASS;
        else
            for (int n = 0; n < NUM_LANES; n++)
                if (bert_run && bert_en_r[n] && err_cnt[n] >= limit_r)
                    pass_r[n] <= 1'b0;
    end

    // Sync error low pulse per link
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            err_acc_r <= '0;
            low_r     <= '0;
            half_r    <= '0;
            for (int k = 0; k < NUM_LINKS; k++)
                low_cnt_r[k] <= '0;
        end
        else
        begin
            for (int k = 0; k < NUM_LINKS; k++)
            begin
                err_acc_r[k] <= multiframe_end_i[k] ? 1'b0 : (err_acc_r[k] | char_err[k]);
                if (raise_err[k])
                begin
                    low_r[k]     <= 1'b1;
                    half_r[k]    <= (low_dur == DUR_HALF);
                    low_cnt_r[k] <= (low_dur == DUR_ONE || low_dur == DUR_HALF) ?
                                    DUR_CYC_1 : DUR_CYC_2;
                end
                else if (low_cnt_r[k] > DUR_CYC_1)
                    low_cnt_r[k] <= low_cnt_r[k] - 2'd1;
                else
                begin
                    low_r[k]     <= 1'b0;
                    half_r[k]    <= 1'b0;
                    low_cnt_r[k] <= '0;
                end
            end
        end
    end

    // Half-cycle mode releases the output on the clock's low phase
    assign sync_request_output_n_o  = ~(low_r & (~half_r | {NUM_LINKS{clk_i}}));
    assign logical_lane_o           = xbar_r;
    assign serializer_setup_value_o = serdes_r;
    assign reg_rdata_o              = rdata_r;
    assign reg_rvalid_o             = rvalid_r;
endmodule

// file: verilog/slx_pkg.sv
// Constants shared by the lane crossbar, sync error and bit-error test logic
package slx_pkg;
    localparam int          NUM_LANES   = 8;
    localparam int          NUM_LINKS   = 2;
    localparam int          CNT_W       = 24;
    localparam int          ADDR_W      = 12;

    // Register offsets
    localparam logic [11:0] OFS_MAP_0_1 = 12'h308;
    localparam logic [11:0] OFS_MAP_2_3 = 12'h309;
    localparam logic [11:0] OFS_MAP_4_5 = 12'h30a;
    localparam logic [11:0] OFS_MAP_6_7 = 12'h30b;
    localparam logic [11:0] OFS_FULL    = 12'h30c;
    localparam logic [11:0] OFS_EMPTY   = 12'h30d;
    localparam logic [11:0] OFS_SYNC    = 12'h312;
    localparam logic [11:0] OFS_SERDES  = 12'h314;
    localparam logic [11:0] OFS_BERT_EN = 12'h315;
    localparam logic [11:0] OFS_BERT_CT = 12'h316;
    localparam logic [11:0] OFS_LIM_LO  = 12'h317;
    localparam logic [11:0] OFS_LIM_MI  = 12'h318;
    localparam logic [11:0] OFS_LIM_HI  = 12'h319;
    localparam logic [11:0] OFS_CNT_LO  = 12'h31a;
    localparam logic [11:0] OFS_CNT_MI  = 12'h31b;
    localparam logic [11:0] OFS_CNT_HI  = 12'h31c;
    localparam logic [11:0] OFS_PASS    = 12'h31d;

    // Reset values
    localparam logic [7:0]  RST_MAP_0_1 = 8'h08;
    localparam logic [7:0]  RST_MAP_2_3 = 8'h1a;
    localparam logic [7:0]  RST_MAP_4_5 = 8'h2c;
    localparam logic [7:0]  RST_MAP_6_7 = 8'h3e;
    localparam logic [7:0]  RST_ZERO    = 8'h00;
    localparam logic [7:0]  RST_PASS    = 8'hff;

    // Field positions
    localparam int          MAP_LO_POS  = 0;
    localparam int          MAP_HI_POS  = 3;
    localparam int          DUR_POS     = 4;
    localparam int          SEL_POS     = 4;
    localparam int          PAT_POS     = 2;
    localparam int          RUN_POS     = 1;
    localparam int          HOLD_POS    = 0;

    // Sync low duration codes and their cycle counts
    localparam logic [1:0]  DUR_HALF    = 2'b00;
    localparam logic [1:0]  DUR_ONE     = 2'b01;
    localparam logic [1:0]  DUR_TWO     = 2'b10;
    localparam logic [1:0]  DUR_CYC_1   = 2'd1;
    localparam logic [1:0]  DUR_CYC_2   = 2'd2;

    // Pattern codes
    localparam logic [1:0]  PAT_PRBS7   = 2'b00;
    localparam logic [1:0]  PAT_PRBS15  = 2'b01;
    localparam logic [1:0]  PAT_PRBS31  = 2'b10;

    // Bits of history before a checker starts counting
    localparam logic [4:0]  FILL_BITS   = 5'd31;
endpackage
